// [hw/cgr_regs.v]
// The register addresses and the AXI4-Lite slave port were decided locally.
`include "cgr_consts.vh"
module cgr_regs (
  input  wire        clock,
  input  wire        rst_b,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [1:0]  mode_select,
  input  wire        clock_loss_detect_off,
  input  wire        gen_off,
  input  wire [1:0]  mode_active_async,
  input  wire        ref_crystal_async,
  input  wire        fll_locked_async,
  input  wire        lock_lost_async,
  input  wire        clock_lost_async,
  input  wire        ext_ref_stable_async,
  input  wire        dco_toggling_async,
  input  wire        dco_err_ok_async,
  input  wire        dco_sample,
  output reg  [4:0]  fll_mult_factor,
  output reg  [7:0]  output_div_factor,
  output wire        mult_busy,
  output wire        div_busy,
  output reg         osc_stable,
  output reg         engage_fll,
  output reg         dco_monitor_en,
  output reg         clockgen_irq,
  output reg         clockgen_reset_req
);
  reg        lock_loss_reset_sel_q;
  reg        clock_loss_reset_sel_q;
  reg        lock_lost_sticky_q;
  reg        clock_lost_sticky_q;
  reg        clockgen_irq_flag_q;
  reg        clr_armed_q;
  reg [1:0]  stable_cnt_q;
  reg        ll_prev_q;
  reg        cl_prev_q;
  reg        aw_q;
  reg        w_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  wire [2:0] fll_mult_sel;
  wire [2:0] output_div_sel;
  wire [1:0] mode_report;
  wire       ref_source_report;
  wire       locked_s;
  wire       lock_lost_s;
  wire       clock_lost_s;
  wire       ext_ref_ok;
  wire       dco_tog_s;
  wire       dco_err_s;
  wire [7:0] stat1;
  wire [7:0] ctrl2;
  wire       lock_shown;
  wire       do_write;
  wire       wr_ctrl2;
  wire       wr_stat1;
  wire       rd_stat1;
  wire       ll_event;
  wire       cl_event;
  wire       new_event;

  cgr_sync2 #(.W(9)) u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .d     ({mode_active_async, ref_crystal_async, fll_locked_async, lock_lost_async,
             clock_lost_async, ext_ref_stable_async, dco_toggling_async, dco_err_ok_async}),
    .q     ({mode_report, ref_source_report, locked_s, lock_lost_s,
             clock_lost_s, ext_ref_ok, dco_tog_s, dco_err_s})
  ); // RL7 RL12

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign do_write      = aw_q && w_q && !s_axi_bvalid;
  assign wr_ctrl2      = do_write && (awaddr_q == `CGR_OFF_CTRL2) && wstrb_q[0];
  assign wr_stat1      = do_write && (awaddr_q == `CGR_OFF_STAT1) && wstrb_q[0];
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_stat1      = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `CGR_OFF_STAT1);

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awaddr_q     <= 12'h000;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CGR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == `CGR_OFF_CTRL2 || awaddr_q == `CGR_OFF_STAT1 ||
                         awaddr_q == `CGR_OFF_STAT2) ? `CGR_RESP_OKAY : `CGR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  cgr_field_apply u_mult (
    .clock   (clock),
    .rst_b   (rst_b),
    .wr      (wr_ctrl2),
    .wdata   (wdata_q[6:4]),
    .value_q (fll_mult_sel),
    .busy    (mult_busy)
  );

  cgr_field_apply u_div (
    .clock   (clock),
    .rst_b   (rst_b),
    .wr      (wr_ctrl2),
    .wdata   (wdata_q[2:0]),
    .value_q (output_div_sel),
    .busy    (div_busy)
  );

  always @* begin
    fll_mult_factor = {1'b0, fll_mult_sel, 1'b0} + 5'h04; // RL2 RL3
  end

  always @* begin
    case (output_div_sel) // RL6 RL3
      3'h0:    output_div_factor = 8'h01;
      3'h1:    output_div_factor = 8'h02;
      3'h2:    output_div_factor = 8'h04;
      3'h3:    output_div_factor = 8'h08;
      3'h4:    output_div_factor = 8'h10;
      3'h5:    output_div_factor = 8'h20;
      3'h6:    output_div_factor = 8'h40;
      default: output_div_factor = 8'h80;
    endcase
  end

  // lock bit hidden outside FLL-engaged modes
  assign lock_shown = locked_s && !gen_off &&
                      (mode_report == `CGR_MODE_FEI || mode_report == `CGR_MODE_FEE); // RL10 RL21

  assign ll_event  = lock_lost_s && !ll_prev_q;
  assign cl_event  = clock_lost_s && !cl_prev_q && !clock_loss_detect_off; // RL22
  assign new_event = (ll_event && !lock_loss_reset_sel_q) || (cl_event && !clock_loss_reset_sel_q);

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lock_loss_reset_sel_q  <= 1'b0;
      clock_loss_reset_sel_q <= 1'b0;
      lock_lost_sticky_q     <= 1'b0;
      clock_lost_sticky_q    <= 1'b0;
      clockgen_irq_flag_q    <= 1'b0;
      clr_armed_q            <= 1'b0;
      ll_prev_q              <= 1'b0;
      cl_prev_q              <= 1'b0;
      clockgen_irq           <= 1'b0;
      clockgen_reset_req     <= 1'b0;
    end else begin
      ll_prev_q <= lock_lost_s;
      cl_prev_q <= clock_lost_s;
      if (wr_ctrl2) begin
        lock_loss_reset_sel_q  <= wdata_q[`CGR_BIT_LOLSEL];
        clock_loss_reset_sel_q <= wdata_q[`CGR_BIT_LOCSEL];
      end
      if (ll_event) begin
        lock_lost_sticky_q <= 1'b1; // RL9
      end else if (wr_stat1 && clr_armed_q && wdata_q[`CGR_BIT_IRQF]) begin
        lock_lost_sticky_q <= 1'b0;
      end
      if (cl_event) begin
        clock_lost_sticky_q <= 1'b1; // RL11
      end else if (wr_stat1 && clr_armed_q && wdata_q[`CGR_BIT_IRQF]) begin
        clock_lost_sticky_q <= 1'b0;
      end
      // read with flag set arms, write of one clears; new event wins
      if (new_event) begin
        clockgen_irq_flag_q <= 1'b1; // RL13
        clr_armed_q         <= 1'b0; // RL14
      end else if (wr_stat1 && clr_armed_q && wdata_q[`CGR_BIT_IRQF]) begin // RL15
        clockgen_irq_flag_q <= 1'b0; // RL13
        clr_armed_q         <= 1'b0;
      end else if (rd_stat1 && clockgen_irq_flag_q) begin
        clr_armed_q <= 1'b1;
      end
      clockgen_irq       <= clockgen_irq_flag_q;
      clockgen_reset_req <= (lock_lost_sticky_q && lock_loss_reset_sel_q) || // RL1 RL20
                            (clock_lost_sticky_q && clock_loss_reset_sel_q); // RL5
    end
  end

  // oscillator stability: two in-tolerance samples in a row
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stable_cnt_q   <= 2'h0;
      osc_stable     <= 1'b0;
      engage_fll     <= 1'b0;
      dco_monitor_en <= 1'b0;
    end else begin
      if (gen_off) begin
        stable_cnt_q <= 2'h0;
        osc_stable   <= 1'b0; // RL19
      end else if (dco_sample) begin
        if (dco_err_s && dco_tog_s) begin
          if (stable_cnt_q != 2'h2) begin
            stable_cnt_q <= stable_cnt_q + 2'h1;
          end
          if (stable_cnt_q >= 2'h1) begin
            osc_stable <= 1'b1; // RL16
          end
        end else begin
          stable_cnt_q <= 2'h0;
          osc_stable   <= 1'b0;
        end
      end
      engage_fll     <= !gen_off && mode_select[0] && osc_stable; // RL17
      dco_monitor_en <= (mode_report == `CGR_MODE_SELF) && osc_stable; // RL18
    end
  end

  assign ctrl2 = {lock_loss_reset_sel_q, fll_mult_sel, clock_loss_reset_sel_q, output_div_sel};
  assign stat1 = {mode_report, ref_source_report, lock_lost_sticky_q, lock_shown,
                  clock_lost_sticky_q, ext_ref_ok, clockgen_irq_flag_q}; // RL7 RL8 RL12

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CGR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `CGR_RESP_OKAY;
      case (s_axi_araddr)
        `CGR_OFF_CTRL2: s_axi_rdata <= {24'h00_0000, ctrl2};
        `CGR_OFF_STAT1: s_axi_rdata <= {24'h00_0000, stat1};
        `CGR_OFF_STAT2: s_axi_rdata <= {31'h0000_0000, osc_stable};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `CGR_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // cgr_regs

// [pkg/cgr_consts.vh]
// How it works
// [RL1] lock-loss select acts only while the lock-lost sticky flag is set
// [RL2] multiplier field bits 6:4 maps codes to factors 4,6,8,10,..,16,18
// [RL3] multiplier codes 100/101 give 12/14; divider codes 100/101 give 16/32
// [RL4] a field write is ignored while the previous write to it is pending
// [RL5] clock-loss select bit 3: 0 raises interrupt, 1 raises reset
// [RL6] divider field bits 2:0 maps codes to 1,2,4,8,..,64,128
// [RL7] mode report bits 7:6 follows synchronised mode, same encoding as select
// [RL8] reference report reads 0 for external clock, 1 for crystal
// [RL9] lock-lost flag bit 4 sets on unexpected lock loss and holds until cleared
// [RL10] lock bit reads lock, forced low in off, self-clocked and bypassed modes
// [RL11] clock-lost flag bit 2 sets on clock loss and holds until cleared
// [RL12] external reference ok bit reads 1 only when reference is stable
// [RL13] irq flag bit 0 sets on pending event; cleared by read-then-write-one
// [RL14] a new event during the clear sequence restarts it, flag stays set
// [RL15] writing 0 to the irq flag has no effect
// [RL16] oscillator stable after two consecutive in-tolerance samples with toggling clock
// [RL17] leaving off with select X1 waits for oscillator stable before engaging
// [RL18] self-clocked mode monitors the oscillator clock only once stable
// [RL19] oscillator stable clears on entering off state
// [RL20] lock-loss select: 0 raises interrupt, 1 raises reset
// [RL21] mode codes: 00 self, 01 engaged internal, 10 bypassed ext, 11 engaged ext
// [RL22] clock-loss detect off bit: 0 enables detection, 1 disables it
`ifndef CGR_CONSTS_VH
`define CGR_CONSTS_VH
`define CGR_OFF_CTRL2      12'h000
`define CGR_OFF_STAT1      12'h004
`define CGR_OFF_STAT2      12'h008
`define CGR_CTRL2_RESET    8'h00
`define CGR_BIT_LOLSEL     7
`define CGR_BIT_LOCSEL     3
`define CGR_BIT_LOCK_LOST_STICKY       4
`define CGR_BIT_LOCK       3
`define CGR_BIT_CLOCK_LOST_STICKY       2
`define CGR_BIT_ERCOK      1
`define CGR_BIT_IRQF       0
`define CGR_BIT_REF        5
`define CGR_MODE_SELF      2'b00
`define CGR_MODE_FEI       2'b01
`define CGR_MODE_FBE       2'b10
`define CGR_MODE_FEE       2'b11
`define CGR_APPLY_CYCLES   4'h3
`define CGR_RESP_OKAY      2'b00
`define CGR_RESP_SLVERR    2'b10
`endif

// [hw/cgr_sync2.v]
module cgr_sync2 #(
  parameter W = 1
) (
  input  wire         clock,
  input  wire         rst_b,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // cgr_sync2

// [hw/cgr_field_apply.v]
`include "cgr_consts.vh"
// holds a 3-bit field and its pending-apply timer
module cgr_field_apply (
  input  wire       clock,
  input  wire       rst_b,
  input  wire       wr,
  input  wire [2:0] wdata,
  output reg  [2:0] value_q,
  output wire       busy
);
  reg [3:0] cnt_q;
  assign busy = (cnt_q != 4'h0);
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      value_q <= 3'h0;
      cnt_q   <= 4'h0;
    end else if (wr && !busy) begin // RL4
      value_q <= wdata;
      cnt_q   <= `CGR_APPLY_CYCLES;
    end else if (busy) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // cgr_field_apply

// [verif/cgr_regs_asserts.sv]
module cgr_regs_asserts (
  input wire        clock,
  input wire        rst_b,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire [4:0]  fll_mult_factor,
  input wire [7:0]  output_div_factor,
  input wire        mult_busy,
  input wire        gen_off,
  input wire        osc_stable,
  input wire        engage_fll,
  input wire        dco_monitor_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_off_held;
    gen_off ##1 gen_off;
  endsequence
  AST_WR_ANSWER: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after address and data");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  AST_MULT_SET: assert property (!fll_mult_factor[0] && fll_mult_factor >= 5'h4 && fll_mult_factor <= 5'h12)
    else $error("multiplier factor outside the even set 4 to 18");
  AST_DIV_SET: assert property ($onehot(output_div_factor))
    else $error("divider factor not a power of two");
  AST_MULT_CHG: assert property ($changed(fll_mult_factor) |-> mult_busy || $past(mult_busy))
    else $error("multiplier changed outside an apply window");
  AST_MULT_TIME: assert property ($rose(mult_busy) |-> ##[1:4] !mult_busy)
    else $error("multiplier apply window too long");
  AST_OFF_CLEARS: assert property (s_off_held |-> !osc_stable)
    else $error("oscillator stable kept in off state");
  AST_ENGAGE_WAIT: assert property ($rose(engage_fll) |-> osc_stable || $past(osc_stable))
    else $error("loop engaged before oscillator stable");
  AST_MON_WAIT: assert property ($rose(dco_monitor_en) |-> osc_stable || $past(osc_stable))
    else $error("monitor started before oscillator stable");
endmodule // cgr_regs_asserts

bind cgr_regs cgr_regs_asserts i_chk (.clock, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .fll_mult_factor, .output_div_factor, .mult_busy, .gen_off, .osc_stable, .engage_fll, .dco_monitor_en);

// [verif/clock_gen_ctrl_status_regs_bench.sv]
module clock_gen_ctrl_status_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = '0, rst_b = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rready = '0, clock_loss_detect_off = '0, gen_off = '0, ref_crystal_async = '0, fll_locked_async = '0;
  logic lock_lost_async = '0, clock_lost_async = '0, ext_ref_stable_async = '0, dco_toggling_async = '0;
  logic dco_err_ok_async = '0, dco_sample = '0;
  logic [1:0] mode_select = '0, mode_active_async = '0, s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mult_busy, div_busy;
  logic osc_stable, engage_fll, dco_monitor_en, clockgen_irq, clockgen_reset_req;
  logic [4:0] fll_mult_factor;
  logic [7:0] output_div_factor;
  int n_fail = 0, checks_done = 0, cycles = 0;
  logic [1:0] last_bresp = '0;

  cgr_regs i_cgr_regs (.*);

  initial forever #20 clock = ~clock;

  task automatic test_done;
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      test_done;
    end
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clock);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      if (b) last_bresp = s_axi_bresp;
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask

  task automatic wr_pair(input logic [31:0] d1, input logic [31:0] d2);
    logic aw, w, b;
    int nb;
    nb = 0;
    @(posedge clock);
    s_axi_awaddr <= 12'h000;
    s_axi_wdata <= d1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clock);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) nb++;
      if (b && nb == 1) begin
        s_axi_wdata <= d2;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
      end
    end while (nb < 2);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!v);
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rdata", e, d);
    chk("rresp", (a > 12'h008) ? 32'h2 : 32'h0, {30'h0, r});
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic pulse2;
    repeat (2) begin
      dco_sample <= 1'b1;
      @(posedge clock);
      dco_sample <= 1'b0;
      @(posedge clock);
    end
    wait_n(3);
  endtask

  task automatic t_factors;
    int nt[8] = '{4, 6, 8, 10, 12, 14, 16, 18};
    for (int c = 0; c < 8; c++) begin
      wr(12'h000, c * 32'h11);
      wait_n(5);
      chk("mult", nt[c], fll_mult_factor);
      chk("div", 32'h1 << c, output_div_factor);
      chk_rd(12'h000, c * 32'h11);
    end
  endtask

  task automatic t_status;
    mode_active_async <= 2'b11;
    ref_crystal_async <= 1'b1;
    fll_locked_async <= 1'b1;
    ext_ref_stable_async <= 1'b1;
    wait_n(4);
    chk_rd(12'h004, 32'h0000_00ea);
    mode_active_async <= 2'b01;
    wait_n(4);
    chk_rd(12'h004, 32'h0000_006a);
    mode_active_async <= 2'b10;
    ref_crystal_async <= 1'b0;
    ext_ref_stable_async <= 1'b0;
    wait_n(4);
    chk_rd(12'h004, 32'h0000_0080);
  endtask

  task automatic t_osc;
    dco_toggling_async <= 1'b1;
    dco_err_ok_async <= 1'b1;
    mode_active_async <= 2'b00;
    wait_n(4);
    chk("monitor", 0, dco_monitor_en);
    pulse2;
    chk("osc_stable", 1, osc_stable);
    chk("monitor", 1, dco_monitor_en);
    chk_rd(12'h008, 32'h0000_0001);
    mode_select <= 2'b01;
    gen_off <= 1'b1;
    wait_n(3);
    chk("osc_stable", 0, osc_stable);
    chk("monitor", 0, dco_monitor_en);
    gen_off <= 1'b0;
    wait_n(3);
    chk("engage", 0, engage_fll);
    pulse2;
    chk("engage", 1, engage_fll);
    mode_select <= 2'b00;
    mode_active_async <= 2'b10;
  endtask

  task automatic t_irq;
    logic [31:0] d;
    logic [1:0] r;
    clock_lost_async <= 1'b1;
    wait_n(6);
    chk("irq", 1, clockgen_irq);
    chk("reset_req", 0, clockgen_reset_req);
    chk_rd(12'h004, 32'h0000_0085);
    wr(12'h004, 32'h0000_0000);
    chk_rd(12'h004, 32'h0000_0085);
    wr(12'h004, 32'h0000_0001);
    chk_rd(12'h004, 32'h0000_0080);
    chk("irq", 0, clockgen_irq);
    clock_lost_async <= 1'b0;
    lock_lost_async <= 1'b1;
    wait_n(6);
    rd(12'h004, d, r);
    chk("lock_lost", 32'h0000_0091, d);
    clock_lost_async <= 1'b1;
    wait_n(6);
    wr(12'h004, 32'h0000_0001);
    rd(12'h004, d, r);
    chk("irq_flag", 1, d[0]);
    wr(12'h004, 32'h0000_0001);
    chk_rd(12'h004, 32'h0000_0080);
  endtask

  task automatic t_lolsel;
    lock_lost_async <= 1'b0;
    clock_lost_async <= 1'b0;
    wr(12'h000, 32'h0000_0080);
    wait_n(6);
    chk("reset_req", 0, clockgen_reset_req);
    lock_lost_async <= 1'b1;
    wait_n(6);
    chk("reset_req", 1, clockgen_reset_req);
    chk("irq", 0, clockgen_irq);
    lock_lost_async <= 1'b0;
    wait_n(4);
  endtask

  task automatic t_busy;
    wr_pair(32'h0000_0022, 32'h0000_00d5);
    wait_n(5);
    chk("mult", 8, fll_mult_factor);
    chk("div", 4, output_div_factor);
    chk_rd(12'h000, 32'h0000_00a2);
    wr(12'h000, 32'h0000_0055);
    chk("bresp", 32'h0, {30'h0, last_bresp});
    @(negedge clock);
    chk("mult_busy", 1, mult_busy);
    chk("div_busy", 1, div_busy);
    wait_n(5);
    chk("mult_busy", 0, mult_busy);
    chk("div_busy", 0, div_busy);
    chk("mult", 14, fll_mult_factor);
    chk("div", 32, output_div_factor);
  endtask

  task automatic t_locsel;
    clock_loss_detect_off <= 1'b1;
    wr(12'h000, 32'h0000_0008);
    clock_lost_async <= 1'b1;
    wait_n(6);
    chk("reset_req", 0, clockgen_reset_req);
    clock_lost_async <= 1'b0;
    clock_loss_detect_off <= 1'b0;
    wait_n(6);
    clock_lost_async <= 1'b1;
    wait_n(6);
    chk("reset_req", 1, clockgen_reset_req);
    chk("irq", 0, clockgen_irq);
  endtask

  initial begin
    wait_n(20);
    rst_b <= 1'b1;
    chk_rd(12'h000, 32'h0000_0000);
    chk("mult", 4, fll_mult_factor);
    chk("div", 1, output_div_factor);
    t_factors;
    t_status;
    t_osc;
    t_irq;
    t_lolsel;
    rst_b <= 1'b0;
    wait_n(3);
    rst_b <= 1'b1;
    chk_rd(12'h000, 32'h0000_0000);
    chk("reset_req", 0, clockgen_reset_req);
    t_busy;
    t_locsel;
    wr(12'h00c, 32'h0000_00ff);
    chk("bresp", 32'h2, {30'h0, last_bresp});
    chk_rd(12'h000, 32'h0000_0008);
    chk_rd(12'h00c, 32'h0000_0000);
    test_done;
  end
endmodule // clock_gen_ctrl_status_regs_bench
